// ==== include/swl_pkg.sv ====
// Shared constants and CRC helper for the single-wire register link
package swl_pkg;
	localparam int CLK_HZ = 10000000;
	localparam logic [7:0] SYNC_BYTE = 8'h05;
	localparam logic [7:0] REPLY_ADDR = 8'hFF;
	localparam logic [7:0] CRC_POLY = 8'h07;
	localparam logic [7:0] CRC_INIT = 8'h00;
	localparam logic [2:0] RD_LAST_BYTE = 3'h3;
	localparam logic [2:0] WR_LAST_BYTE = 3'h7;
	localparam logic [6:0] RD_FRAME_BITS = 7'h27;
	localparam logic [6:0] WR_FRAME_BITS = 7'h4F;
	localparam int GAP_BITS = 63;
	localparam int RECOVER_BITS = 12;
	localparam logic [2:0] RELEASE_BITS = 3'h4;
	localparam int DELAY_UNIT_BITS = 8;
	localparam logic [3:0] DELAY_DEFAULT = 4'h1;
	localparam int MIN_BIT_CYCLES = 16;
	localparam int SYNC_SPAN_BITS = 4;
	localparam int HOST_BAUD = 250000;
	localparam int HOST_BIT_CYCLES = CLK_HZ / HOST_BAUD;
	localparam int HOST_REPLY_TIMEOUT_BITS = 255;

	function automatic logic [7:0] crc8_byte(input logic [7:0] crc,
		input logic [7:0] data);
		logic [7:0] c;
		c = crc;
		for (int i = 0; i < 8; i++) begin
			if (c[7] != data[i]) begin
				c = {c[6:0], 1'b0} ^ CRC_POLY;
			end else begin
				c = {c[6:0], 1'b0};
			end
		end
		return c;
	endfunction
endpackage

// ==== include/swl_if.sv ====
// Shared single-wire line joining the device end and the host end
`timescale 1ns/1ps
interface swl_if;
	logic dev_tx;
	logic dev_oe;
	logic host_tx;
	logic host_oe;
	logic line_level;

	// Pull-up keeps the undriven line high
	assign line_level = (dev_oe ? dev_tx : 1'b1) & (host_oe ? host_tx : 1'b1);

	modport device(input line_level, output dev_tx, output dev_oe);
	modport host(input line_level, output host_tx, output host_oe);
endinterface

// ==== hdl/swl_device.sv ====
// Device end of the single-wire link with its write FIFO
`timescale 1ns/1ps
module swl_fifo #(
	parameter int W = 39,
	parameter int DEPTH = 8
)(
	input wire logic clock,
	input wire logic reset,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem_r [DEPTH];
	logic [AW:0] wr_ptr_r;
	logic [AW:0] rd_ptr_r;
	wire full = (wr_ptr_r[AW] != rd_ptr_r[AW]) &&
		(wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
	wire empty = (wr_ptr_r == rd_ptr_r);
	wire push = in_valid && !full;
	wire pop = out_ready && !empty;
	assign in_ready = !full;
	assign out_valid = !empty;
	assign out_data = mem_r[rd_ptr_r[AW-1:0]];

	always_ff @(posedge clock) begin
		if (push) begin
			mem_r[wr_ptr_r[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
		end else begin
			wr_ptr_r <= wr_ptr_r + (AW+1)'(push);
			rd_ptr_r <= rd_ptr_r + (AW+1)'(pop);
		end
	end
endmodule

// What this block does
// - Read request: sync, address, register, CRC bytes
// - Reply uses the request's baud rate
// - Turnaround delay in eight-bit-time units, default eight
// - Reply: sync, 0xFF, register, data MSB first, CRC
// - Driver released four bit times after stop
// - All-ones address never matches a slave
// - Eight-bit CRC ends every datagram
// - CRC poly x^8+x^2+x+1, zero start, LSB first
// - Shift left, XOR 0x07 when bits differ
// - Act only on good CRC and own address
// - Count each accepted write datagram
// - One non-inverted line for both directions
// - Two select pins form address bits 0,1
// - Track sync nibble, drive and reply on reads
// - Host may broadcast identical writes
// - Host sends eight data bits, no parity
// - Host releases line before reply starts
// - Host discards the echo of its bytes
// - Bit time from start fall to sync fall
// - Gap over 63 bits resets; 12 idle bits
// - Register byte top bit: 0 read, 1 write
// - Line rests high when idle
module swl_device #(
	parameter int BW = 16,
	parameter int FIFO_DEPTH = 8
)(
	input wire logic clock,
	input wire logic reset,
	swl_if.device link,
	input wire logic node_addr_bit_lo,
	input wire logic node_addr_bit_hi,
	input wire logic [3:0] reply_turnaround_delay,
	output logic rd_req,
	output logic [6:0] rd_addr,
	input wire logic [31:0] rd_data,
	output logic wr_valid,
	input wire logic wr_ready,
	output logic [6:0] wr_addr,
	output logic [31:0] wr_data,
	output logic [7:0] wr_count
);
	typedef enum logic [4:0] {
		R_IDLE = 5'b00001, R_SYNC = 5'b00010, R_BITS = 5'b00100,
		R_WAIT = 5'b01000, R_RECOV = 5'b10000
	} swl_rx_t;
	typedef enum logic [4:0] {
		T_IDLE = 5'b00001, T_LOAD = 5'b00010, T_DELAY = 5'b00100,
		T_SEND = 5'b01000, T_HOLD = 5'b10000
	} swl_tx_t;

	swl_rx_t rx_st_r;
	swl_tx_t tx_st_r;
	logic line_q_r;
	logic [BW+1:0] meas_r;
	logic nfall_r;
	logic [BW-1:0] bit_len_r;
	logic [BW-1:0] tmr_r;
	logic [3:0] bit_idx_r;
	logic [7:0] sh_r;
	logic [2:0] byte_idx_r;
	logic [7:0] crc_r;
	logic [7:0] buf_r [8];
	logic [BW+5:0] gap_r;
	logic rd_req_r;
	logic [6:0] rd_addr_r;
	logic push_r;
	logic [7:0] wr_count_r;
	logic [BW-1:0] tx_tmr_r;
	logic [79:0] frame_r;
	logic [6:0] tx_bits_r;
	logic [6:0] dly_r;
	logic [2:0] hold_r;
	logic dev_tx_r;
	logic dev_oe_r;
	logic [7:0] rbytes [8];
	logic [7:0] rcrc;

	wire line = link.line_level;
	wire fall = line_q_r && !line;
	wire [BW+1:0] meas_nxt = meas_r + 1'b1;
	wire glitch = meas_nxt < (BW+2)'(swl_pkg::SYNC_SPAN_BITS *
		swl_pkg::MIN_BIT_CYCLES);
	wire [BW-1:0] half = bit_len_r >> 1;
	wire [BW+5:0] gap_lim = (BW+6)'(bit_len_r * swl_pkg::GAP_BITS);
	wire [BW+5:0] idle_lim = (BW+6)'(bit_len_r * swl_pkg::RECOVER_BITS);
	wire [7:0] own_addr = {6'h00, node_addr_bit_hi, node_addr_bit_lo};
	wire is_read = !buf_r[2][7];
	wire last_byte = (byte_idx_r == swl_pkg::RD_LAST_BYTE && is_read) ||
		byte_idx_r == swl_pkg::WR_LAST_BYTE;
	wire addr_ok = buf_r[1] == own_addr;
	wire crc_ok = sh_r == crc_r;
	wire tx_busy = tx_st_r != T_IDLE;
	wire tick = tx_tmr_r == '0;
	wire [3:0] dly_units = (reply_turnaround_delay == 4'h0) ?
		swl_pkg::DELAY_DEFAULT : reply_turnaround_delay;
	wire fifo_in_ready;
	wire [38:0] fifo_out;

	// Own reply is not parsed, so its echo never reaches the decoder
	always_ff @(posedge clock) begin
		line_q_r <= line;
		rd_req_r <= 1'b0;
		push_r <= 1'b0;
		if (reset || tx_busy) begin
			rx_st_r <= R_IDLE;
			byte_idx_r <= 3'h0;
			gap_r <= '0;
		end else begin
			gap_r <= gap_r + 1'b1;
			case (rx_st_r)
			R_IDLE: if (fall) begin
				meas_r <= '0;
				nfall_r <= 1'b0;
				gap_r <= '0;
				byte_idx_r <= 3'h0;
				crc_r <= swl_pkg::CRC_INIT;
				rx_st_r <= R_SYNC;
			end
			R_SYNC: begin
				meas_r <= meas_nxt;
				if (fall && !nfall_r) begin
					nfall_r <= 1'b1;
				end else if (fall && glitch) begin
					gap_r <= '0;
					rx_st_r <= R_RECOV;
				end else if (fall) begin
					bit_len_r <= meas_nxt[BW+1:2];
					tmr_r <= {1'b0, meas_nxt[BW+1:3]};
					sh_r <= swl_pkg::SYNC_BYTE;
					bit_idx_r <= 4'h3;
					rx_st_r <= R_BITS;
				end
			end
			R_BITS: if (tmr_r != '0) begin
				tmr_r <= tmr_r - 1'b1;
			end else if (bit_idx_r != 4'h8) begin
				sh_r[bit_idx_r[2:0]] <= line;
				bit_idx_r <= bit_idx_r + 1'b1;
				tmr_r <= bit_len_r - 1'b1;
			end else if (!line) begin
				gap_r <= '0;
				rx_st_r <= R_RECOV;
			end else begin
				buf_r[byte_idx_r] <= sh_r;
				crc_r <= swl_pkg::crc8_byte(crc_r, sh_r);
				byte_idx_r <= byte_idx_r + 1'b1;
				rx_st_r <= R_WAIT;
				if (last_byte) begin
					rx_st_r <= crc_ok ? R_IDLE : R_RECOV;
					gap_r <= '0;
					rd_req_r <= crc_ok && addr_ok && is_read;
					push_r <= crc_ok && addr_ok && !is_read;
					rd_addr_r <= buf_r[2][6:0];
				end
			end
			R_WAIT: if (fall) begin
				gap_r <= '0;
				tmr_r <= bit_len_r + half;
				bit_idx_r <= 4'h0;
				rx_st_r <= R_BITS;
			end else if (gap_r > gap_lim) begin
				gap_r <= '0;
				rx_st_r <= R_RECOV;
			end
			R_RECOV: if (!line) begin
				gap_r <= '0;
			end else if (gap_r >= idle_lim) begin
				rx_st_r <= R_IDLE;
			end
			default: rx_st_r <= R_IDLE;
			endcase
		end
	end

	// Writes dropped on a full FIFO are not acknowledged in the count
	always_ff @(posedge clock) begin
		if (reset) begin
			wr_count_r <= 8'h00;
		end else if (push_r && fifo_in_ready) begin
			wr_count_r <= wr_count_r + 1'b1;
		end
	end

	swl_fifo #(.W(39), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clock(clock),
		.reset(reset),
		.in_valid(push_r),
		.in_ready(fifo_in_ready),
		.in_data({buf_r[2][6:0], buf_r[3], buf_r[4], buf_r[5], buf_r[6]}),
		.out_valid(wr_valid),
		.out_ready(wr_ready),
		.out_data(fifo_out)
	);

	always_comb begin
		rbytes[0] = swl_pkg::SYNC_BYTE;
		rbytes[1] = swl_pkg::REPLY_ADDR;
		rbytes[2] = {1'b0, rd_addr_r};
		rbytes[3] = rd_data[31:24];
		rbytes[4] = rd_data[23:16];
		rbytes[5] = rd_data[15:8];
		rbytes[6] = rd_data[7:0];
		rcrc = swl_pkg::CRC_INIT;
		for (int i = 0; i < 7; i++) begin
			rcrc = swl_pkg::crc8_byte(rcrc, rbytes[i]);
		end
		rbytes[7] = rcrc;
	end

	always_ff @(posedge clock) begin
		tx_tmr_r <= (tick || tx_st_r == T_IDLE) ? bit_len_r - 1'b1 :
			tx_tmr_r - 1'b1;
		if (reset) begin
			tx_st_r <= T_IDLE;
			dev_tx_r <= 1'b1;
			dev_oe_r <= 1'b0;
		end else begin
			case (tx_st_r)
			T_IDLE: if (rd_req_r) begin
				tx_st_r <= T_LOAD;
			end
			T_LOAD: begin
				for (int i = 0; i < 8; i++) begin
					frame_r[10*i +: 10] <= {1'b1, rbytes[i], 1'b0};
				end
				dly_r <= 7'(dly_units * swl_pkg::DELAY_UNIT_BITS);
				tx_st_r <= T_DELAY;
			end
			T_DELAY: if (tick) begin
				dly_r <= dly_r - 1'b1;
				if (dly_r == 7'h01) begin
					dev_oe_r <= 1'b1;
					dev_tx_r <= frame_r[0];
					frame_r <= frame_r >> 1;
					tx_bits_r <= swl_pkg::WR_FRAME_BITS;
					tx_st_r <= T_SEND;
				end
			end
			T_SEND: if (tick) begin
				if (tx_bits_r == 7'h00) begin
					dev_tx_r <= 1'b1;
					hold_r <= swl_pkg::RELEASE_BITS;
					tx_st_r <= T_HOLD;
				end else begin
					dev_tx_r <= frame_r[0];
					frame_r <= frame_r >> 1;
					tx_bits_r <= tx_bits_r - 1'b1;
				end
			end
			T_HOLD: if (tick) begin
				hold_r <= hold_r - 1'b1;
				if (hold_r == 3'h1) begin
					dev_oe_r <= 1'b0;
					tx_st_r <= T_IDLE;
				end
			end
			default: tx_st_r <= T_IDLE;
			endcase
		end
	end

	assign link.dev_tx = dev_tx_r;
	assign link.dev_oe = dev_oe_r;
	assign rd_req = rd_req_r;
	assign rd_addr = rd_addr_r;
	assign wr_addr = fifo_out[38:32];
	assign wr_data = fifo_out[31:0];
	assign wr_count = wr_count_r;
endmodule

// ==== hdl/swl_host.sv ====
// Host end of the single-wire link: sends requests, collects replies
`timescale 1ns/1ps
module swl_host #(
	parameter int BIT_CYCLES = swl_pkg::HOST_BIT_CYCLES,
	parameter int TIMEOUT_BITS = swl_pkg::HOST_REPLY_TIMEOUT_BITS
)(
	input wire logic clock,
	input wire logic reset,
	swl_if.host link,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic cmd_write,
	input wire logic [7:0] cmd_node,
	input wire logic [6:0] cmd_reg,
	input wire logic [31:0] cmd_data,
	output logic rsp_valid,
	output logic rsp_err,
	output logic [31:0] rsp_data
);
	typedef enum logic [4:0] {
		H_IDLE = 5'b00001, H_SEND = 5'b00010, H_WAIT = 5'b00100,
		H_RECV = 5'b01000, H_GAP = 5'b10000
	} swl_host_t;

	swl_host_t st_r;
	logic [15:0] div_r;
	logic line_q_r;
	logic [79:0] frame_r;
	logic [6:0] bits_r;
	logic wr_r;
	logic [7:0] wait_r;
	logic [3:0] rbit_r;
	logic [2:0] rbyte_r;
	logic [7:0] rsh_r;
	logic [7:0] rbuf_r [7];
	logic host_tx_r;
	logic host_oe_r;
	logic cmd_ready_r;
	logic rsp_valid_r;
	logic rsp_err_r;
	logic [31:0] rsp_data_r;
	logic [7:0] tb [8];
	logic [7:0] tcrc;
	logic [7:0] rcrc;

	wire line = link.line_level;
	wire fall = line_q_r && !line;
	wire tick = div_r == 16'h0000;
	wire reply_ok = rcrc == rsh_r && rbuf_r[0] == swl_pkg::SYNC_BYTE &&
		rbuf_r[1] == swl_pkg::REPLY_ADDR;

	always_comb begin
		tb[0] = swl_pkg::SYNC_BYTE;
		tb[1] = cmd_node;
		tb[2] = {cmd_write, cmd_reg};
		tb[3] = cmd_data[31:24];
		tb[4] = cmd_data[23:16];
		tb[5] = cmd_data[15:8];
		tb[6] = cmd_data[7:0];
		tcrc = swl_pkg::CRC_INIT;
		for (int i = 0; i < 7; i++) begin
			if (i < 3 || cmd_write) begin
				tcrc = swl_pkg::crc8_byte(tcrc, tb[i]);
			end
		end
		tb[7] = tcrc;
		if (!cmd_write) begin
			tb[3] = tcrc;
		end
		rcrc = swl_pkg::CRC_INIT;
		for (int i = 0; i < 7; i++) begin
			rcrc = swl_pkg::crc8_byte(rcrc, rbuf_r[i]);
		end
	end

	always_ff @(posedge clock) begin
		line_q_r <= line;
		div_r <= tick ? 16'(BIT_CYCLES - 1) : div_r - 1'b1;
		rsp_valid_r <= 1'b0;
		if (reset) begin
			st_r <= H_IDLE;
			host_tx_r <= 1'b1;
			host_oe_r <= 1'b0;
			cmd_ready_r <= 1'b0;
			rsp_err_r <= 1'b0;
			rsp_data_r <= 32'h0000_0000;
		end else begin
			case (st_r)
			H_IDLE: begin
				cmd_ready_r <= 1'b1;
				if (cmd_valid && cmd_ready_r) begin
					for (int i = 0; i < 8; i++) begin
						frame_r[10*i +: 10] <= {1'b1, tb[i], 1'b0};
					end
					wr_r <= cmd_write;
					// One extra tick keeps the last stop bit driven in full
					bits_r <= cmd_write ? swl_pkg::WR_FRAME_BITS + 7'h01 :
						swl_pkg::RD_FRAME_BITS + 7'h01;
					cmd_ready_r <= 1'b0;
					div_r <= 16'h0000;
					host_oe_r <= 1'b1;
					st_r <= H_SEND;
				end
			end
			H_SEND: if (tick) begin
				host_tx_r <= frame_r[0];
				frame_r <= frame_r >> 1;
				bits_r <= bits_r - 1'b1;
				if (bits_r == 7'h00) begin
					host_tx_r <= 1'b1;
					host_oe_r <= 1'b0;
					rbyte_r <= 3'h0;
					wait_r <= 8'h00;
					rsp_err_r <= 1'b0;
					rsp_valid_r <= wr_r;
					st_r <= wr_r ? H_GAP : H_WAIT;
				end
			end
			// Line is only sampled after sending, so echoes are dropped
			H_WAIT: if (fall) begin
				div_r <= 16'(BIT_CYCLES / 2);
				rbit_r <= 4'h0;
				st_r <= H_RECV;
			end else if (tick) begin
				wait_r <= wait_r + 1'b1;
				if (wait_r == 8'(TIMEOUT_BITS)) begin
					rsp_err_r <= 1'b1;
					rsp_valid_r <= 1'b1;
					wait_r <= 8'h00;
					st_r <= H_GAP;
				end
			end
			H_RECV: if (tick) begin
				rbit_r <= rbit_r + 1'b1;
				if (rbit_r != 4'h0 && rbit_r != 4'h9) begin
					rsh_r <= {line, rsh_r[7:1]};
				end
				if (rbit_r == 4'h9 && rbyte_r == 3'h7) begin
					rsp_data_r <= {rbuf_r[3], rbuf_r[4], rbuf_r[5], rbuf_r[6]};
					rsp_err_r <= !reply_ok || !line;
					rsp_valid_r <= 1'b1;
					wait_r <= 8'h00;
					st_r <= H_GAP;
				end else if (rbit_r == 4'h9) begin
					rbuf_r[rbyte_r] <= rsh_r;
					rbyte_r <= rbyte_r + 1'b1;
					wait_r <= 8'h00;
					st_r <= H_WAIT;
				end
			end
			H_GAP: if (tick) begin
				wait_r <= wait_r + 1'b1;
				if (wait_r == 8'(swl_pkg::RECOVER_BITS)) begin
					st_r <= H_IDLE;
				end
			end
			default: st_r <= H_IDLE;
			endcase
		end
	end

	assign link.host_tx = host_tx_r;
	assign link.host_oe = host_oe_r;
	assign cmd_ready = cmd_ready_r;
	assign rsp_valid = rsp_valid_r;
	assign rsp_err = rsp_err_r;
	assign rsp_data = rsp_data_r;
endmodule

// ==== verification/swl_link_asserts.sv ====
// Checker on the shared wire between host and device ends
`timescale 1ns/1ps
module swl_link_asserts #(
	parameter int BITC = 16
)(
	input wire logic clock,
	input wire logic reset,
	input wire logic dev_tx,
	input wire logic dev_oe,
	input wire logic host_tx,
	input wire logic host_oe,
	input wire logic line_level
);
	// Device bit length is measured, so allow one cycle per bit of drift
	localparam int REPLY_LO = 84 * (BITC - 1);
	localparam int REPLY_HI = 84 * (BITC + 1);
	int dev_oe_cnt;
	int host_oe_cnt;
	int dev_hi_cnt;
	int idle_cnt;
	default clocking @(posedge clock);
	endclocking
	default disable iff (reset);
	always_ff @(posedge clock) begin
		if (reset) begin
			dev_oe_cnt <= 0;
			host_oe_cnt <= 0;
			dev_hi_cnt <= 0;
			idle_cnt <= 4095;
		end else begin
			dev_oe_cnt <= dev_oe ? dev_oe_cnt + 1 : 0;
			host_oe_cnt <= host_oe ? host_oe_cnt + 1 : 0;
			dev_hi_cnt <= (dev_oe && dev_tx) ? dev_hi_cnt + 1 : 0;
			idle_cnt <= !line_level ? 0 : (idle_cnt < 4095 ? idle_cnt + 1 : 4095);
		end
	end
	property p_dev_idle_high;
		!dev_oe |-> dev_tx;
	endproperty
	a_dev_idle_high: assert property (p_dev_idle_high)
		else $error("device drive value low while released");
	property p_host_idle_high;
		!host_oe |-> host_tx;
	endproperty
	a_host_idle_high: assert property (p_host_idle_high)
		else $error("host drive value low while released");
	property p_no_contention;
		!(dev_oe && host_oe);
	endproperty
	a_no_contention: assert property (p_no_contention)
		else $error("both ends drive the wire");
	property p_dev_start_low;
		$rose(dev_oe) |-> !dev_tx;
	endproperty
	a_dev_start_low: assert property (p_dev_start_low)
		else $error("reply does not open with a start bit");
	property p_host_start_low;
		$rose(host_oe) |-> ##[0:2] !host_tx;
	endproperty
	a_host_start_low: assert property (p_host_start_low)
		else $error("request does not open with a start bit");
	property p_reply_len;
		$fell(dev_oe) |-> dev_oe_cnt >= REPLY_LO && dev_oe_cnt <= REPLY_HI;
	endproperty
	a_reply_len: assert property (p_reply_len)
		else $error("reply drive span is not 84 bit times");
	property p_release_tail;
		$fell(dev_oe) |-> dev_hi_cnt >= 5 * (BITC - 1);
	endproperty
	a_release_tail: assert property (p_release_tail)
		else $error("driver released before four bit times");
	property p_host_frame_len;
		$fell(host_oe) |-> (host_oe_cnt >= 40 * BITC - 2
			&& host_oe_cnt <= 40 * BITC + 2)
			|| (host_oe_cnt >= 80 * BITC - 2 && host_oe_cnt <= 80 * BITC + 2);
	endproperty
	a_host_frame_len: assert property (p_host_frame_len)
		else $error("request is not 4 or 8 framed bytes");
	property p_idle_gap;
		$rose(host_oe) |-> idle_cnt >= 12 * BITC;
	endproperty
	a_idle_gap: assert property (p_idle_gap)
		else $error("request after less than 12 idle bit times");
	property p_turnaround;
		$rose(dev_oe) |-> idle_cnt >= 8 * (BITC - 1);
	endproperty
	a_turnaround: assert property (p_turnaround)
		else $error("reply starts before eight bit times");
endmodule

// ==== verification/testbench.sv ====
// Self-checking bench joining the host end to the device end
`timescale 1ns/1ps
module testbench;
	localparam int BITC = 16;
	logic clock, reset, lo, hi, cmd_valid, cmd_write, wr_ready;
	logic cmd_ready, rsp_valid, rsp_err, rd_req, wr_valid;
	logic [3:0] dly;
	logic [7:0] cmd_node, wr_count;
	logic [6:0] cmd_reg, rd_addr, wr_addr;
	logic [31:0] cmd_data, rd_data, rsp_data, wr_data, r;
	logic [31:0] mem [128];
	logic [38:0] wq [$];
	int fail_count, n_checks, seed, exp_cnt;
	swl_if link_if();
	swl_device i_swl_device(.clock(clock), .reset(reset), .link(link_if),
		.node_addr_bit_lo(lo), .node_addr_bit_hi(hi),
		.reply_turnaround_delay(dly), .rd_req(rd_req), .rd_addr(rd_addr),
		.rd_data(rd_data), .wr_valid(wr_valid), .wr_ready(wr_ready),
		.wr_addr(wr_addr), .wr_data(wr_data), .wr_count(wr_count));
	swl_host #(.BIT_CYCLES(BITC)) i_swl_host(.clock(clock), .reset(reset),
		.link(link_if), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.cmd_write(cmd_write), .cmd_node(cmd_node), .cmd_reg(cmd_reg),
		.cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_err(rsp_err),
		.rsp_data(rsp_data));
	swl_link_asserts #(.BITC(BITC)) i_swl_link_asserts(.clock(clock),
		.reset(reset), .dev_tx(link_if.dev_tx), .dev_oe(link_if.dev_oe),
		.host_tx(link_if.host_tx), .host_oe(link_if.host_oe),
		.line_level(link_if.line_level));
	initial begin
		clock = 0;
		forever #50 clock = ~clock;
	end
	// Register file stand-in answering the device's read strobe
	always @(posedge clock) begin
		if (rd_req === 1'b1) rd_data <= mem[rd_addr];
	end
	task automatic tally_and_finish();
		$display("checks=%0d errors=%0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] nd,
		input logic [6:0] rg, input logic [31:0] d);
		int k;
		k = 0;
		do begin
			@(negedge clock);
			k++;
		end while (cmd_ready !== 1'b1 && k < 9000);
		if (k >= 9000) fail_count++;
		@(posedge clock);
		cmd_valid <= 1;
		cmd_write <= w;
		cmd_node <= nd;
		cmd_reg <= rg;
		cmd_data <= d;
		@(posedge clock);
		cmd_valid <= 0;
		@(negedge clock);
		chk(cmd_ready, 1'b0);
		k = 0;
		do begin
			@(negedge clock);
			k++;
		end while (rsp_valid !== 1'b1 && k < 20000);
		if (k >= 20000) fail_count++;
	endtask
	task automatic rd(input logic [7:0] nd, input logic [6:0] rg,
		input logic err);
		xfer(0, nd, rg, 32'h0);
		chk(rsp_err, err);
		if (!err) chk(rsp_data, mem[rg]);
	endtask
	initial begin
		seed = 46;
		{reset, lo, hi, dly, cmd_node, cmd_reg} = {1'b1, 21'h0};
		{cmd_valid, cmd_write, wr_ready, cmd_data} = 35'h0;
		for (int i = 0; i < 128; i++) mem[i] = $random(seed);
		repeat (20) @(posedge clock);
		reset <= 0;
		// Every delay step up to 5, each at a random node address
		for (int i = 0; i < 6; i++) begin
			r = $random(seed);
			@(posedge clock);
			{hi, lo} <= r[1:0];
			dly <= 4'(i);
			rd({6'h0, r[1:0]}, r[10:4], 1'b0);
		end
		rd({6'h0, hi, ~lo}, 7'h11, 1'b1);
		rd(8'hFF, 7'h12, 1'b1);
		// Sink stalled: ninth write must be dropped with no count
		for (int i = 0; i < 9; i++) begin
			r = $random(seed);
			xfer(1, {6'h0, hi, lo}, r[6:0], ~r);
			if (wq.size() < 8) begin
				wq.push_back({r[6:0], ~r});
				exp_cnt++;
			end
		end
		xfer(1, {6'h0, ~hi, lo}, 7'h05, 32'h0);
		chk(wr_count, exp_cnt[7:0]);
		rd({6'h0, hi, lo}, 7'h7F, 1'b0);
		chk(wr_count, exp_cnt[7:0]);
		while (wq.size() > 0) begin
			@(negedge clock);
			chk(wr_valid, 1'b1);
			chk({wr_addr, wr_data}, wq.pop_front());
			@(posedge clock);
			wr_ready <= 1;
			@(posedge clock);
			wr_ready <= 0;
		end
		@(negedge clock);
		chk(wr_valid, 1'b0);
		tally_and_finish();
	end
	initial begin
		repeat (90000) @(posedge clock);
		fail_count++;
		tally_and_finish();
	end
endmodule
